// [rtl/acrb_defs.svh]
// Offsets, field positions, reset values and counts for the config bank.
// Assumes inclusion by bare name from the package, compiled ahead of the design modules.
`ifndef ACRB_DEFS_SVH
`define ACRB_DEFS_SVH

`define ACRB_ADDR_W        3
`define ACRB_DATA_W        16
`define ACRB_OFS_CTRL1     3'h1
`define ACRB_OFS_CTRL2     3'h2
`define ACRB_OFS_OFFSET    3'h3
`define ACRB_OFS_GAIN      3'h4
`define ACRB_OFS_OVR       3'h5
`define ACRB_RST_CTRL1     16'h001a
`define ACRB_RST_CTRL2     16'h009b
`define ACRB_RST_OFFSET    16'h0000
`define ACRB_RST_GAIN      16'ha000
`define ACRB_RST_OVR       16'hcccc
`define ACRB_C1_LOAD       15
`define ACRB_C1_RD_OVR     14
`define ACRB_C1_RD_GAIN    13
`define ACRB_C1_RD_OFS     12
`define ACRB_C1_RD_STAT    11
`define ACRB_C1_ALIGN      9
`define ACRB_C1_TAPS_HI    8
`define ACRB_C1_TAPS_LO    5
`define ACRB_C1_F3EN       4
`define ACRB_C1_ONE        3
`define ACRB_C1_DEC_HI     2
`define ACRB_C2_SLEEP      3
`define ACRB_C2_LOWPWR     2
`define ACRB_C2_ONE        1
`define ACRB_C2_AMPOFF     0
`define ACRB_C2_LIVE_MASK  16'h000f
`define ACRB_ST_LOWPWR     9
`define ACRB_ST_OVR        8
`define ACRB_ST_DLOK       7
`define ACRB_ST_CUSTOM     5
`define ACRB_ST_F3EN       4
`define ACRB_ST_ONE        3
`define ACRB_COEF_PER_TAP  6

`endif

// [rtl/acrb_pkg.sv]
// Types shared by the two ends of the config bank link.
// Assumes acrb_defs.svh on the include path.
`include "acrb_defs.svh"
package acrb_pkg;
    typedef logic [`ACRB_ADDR_W-1:0] acrb_addr_t;
    typedef logic [`ACRB_DATA_W-1:0] acrb_word_t;
    typedef enum logic [2:0]
    {
        ACRB_RD_RESULT,
        ACRB_RD_OVR,
        ACRB_RD_GAIN,
        ACRB_RD_OFFSET,
        ACRB_RD_STATUS
    } acrb_rdsel_t;
    typedef enum logic [1:0]
    {
        ACRB_DEC4,
        ACRB_DEC8,
        ACRB_DEC16,
        ACRB_DEC32
    } acrb_decim_t;
endpackage : acrb_pkg

// [rtl/acrb_link_if.sv]
// Word-level write/read link between host controller and config bank.
// Assumes one clock shared by both ends; the bench joins them.
`timescale 1ns/100ps
interface acrb_link_if
    import acrb_pkg::*;
(
    input wire logic core_clk
);
    logic       wrValid;   // Host writes addr + data this cycle
    acrb_addr_t wrAddr;
    acrb_word_t wrData;
    logic       rdReq;     // Host requests a read word
    logic       rdValid;   // Device answers with rdData
    logic [23:0] rdData;

    modport device
    (
        input  wrValid, wrAddr, wrData, rdReq,
        output rdValid, rdData
    );
    modport host
    (
        output wrValid, wrAddr, wrData, rdReq,
        input  rdValid, rdData
    );
endinterface : acrb_link_if

// [rtl/acrb_host_end.sv]
// Host controller end: turns user commands into link writes and reads.
// Assumes user holds a command until cmdReady is seen high.
`timescale 1ns/100ps
module acrb_host_end
    import acrb_pkg::*;
(
    input  wire logic          core_clk,  // System clock
    input  wire logic          rst_n,     // Sync reset, active low
    acrb_link_if.host          link,      // Link to device
    input  wire logic          cmdWrite,  // Write request
    input  wire logic          cmdRead,   // Read request
    input  wire acrb_addr_t    cmdAddr,   // Register address
    input  wire acrb_word_t    cmdData,   // Write data
    output logic               cmdReady,  // Idle, command accepted
    output logic [23:0]        rspData,   // Last read word
    output logic               rspValid   // Read word pulse
);
    logic       busy_q;
    logic       wrV_q;
    acrb_addr_t wrA_q;
    acrb_word_t wrD_q;

    // Forces the fixed bits the device expects (see RQ13)
    function automatic acrb_word_t fixBits(acrb_addr_t a, acrb_word_t d);
        acrb_word_t r;
        r = d;
        if (a == `ACRB_OFS_CTRL1)
        begin
            r[10] = 1'b0;
            r[`ACRB_C1_ONE] = 1'b1;
        end
        else if (a == `ACRB_OFS_CTRL2)
        begin
            r[`ACRB_C2_ONE] = 1'b1;
        end
        return r;
    endfunction : fixBits

    // At most one read-select per write, keep highest (see RQ8)
    function automatic acrb_word_t oneSel(acrb_addr_t a, acrb_word_t d);
        acrb_word_t r;
        r = d;
        if (a == `ACRB_OFS_CTRL1)
        begin
            if (r[14])
                r[13:11] = 3'h0;
            else if (r[13])
                r[12:11] = 2'h0;
            else if (r[12])
                r[11] = 1'b0;
        end
        return r;
    endfunction : oneSel

    assign cmdReady = !busy_q;

    // One address+word per write; taps travel with load arm (see RQ1, RQ3)
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wrV_q <= 1'b0;
            wrA_q <= '0;
            wrD_q <= '0;
        end
        else
        begin
            wrV_q <= cmdWrite && !busy_q;
            if (cmdWrite && !busy_q)
            begin
                wrA_q <= cmdAddr;
                wrD_q <= fixBits(cmdAddr, oneSel(cmdAddr, cmdData));
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            busy_q <= 1'b0;
        else if (cmdRead && !busy_q)
            busy_q <= 1'b1;
        else if (link.rdValid)
            busy_q <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rspData  <= '0;
            rspValid <= 1'b0;
        end
        else
        begin
            rspValid <= link.rdValid;
            if (link.rdValid)
                rspData <= link.rdData;
        end
    end

    assign link.wrValid = wrV_q;
    assign link.wrAddr  = wrA_q;
    assign link.wrData  = wrD_q;
    assign link.rdReq   = cmdRead && !busy_q;
endmodule : acrb_host_end

// [rtl/acrb_device_end.sv]
// Config bank of the converter: two control registers plus readback.
// Assumes the host keeps writes and reads on the shared core_clk.
// Notes on behaviour
// (RQ1) Write is address then 16-bit word
// (RQ2) Load arm turns next writes into coefficients
// (RQ3) Host sets tap count with load arm
// (RQ4) Overrange select returns threshold on next read
// (RQ5) Gain select returns gain on next read
// (RQ6) Offset select returns offset on next read
// (RQ7) Status select returns status on next read
// (RQ8) Host sets at most one read select
// (RQ9) Bits 15 to 9 self-clear after acting
// (RQ10) Align bit starts filter synchronisation
// (RQ11) Bit 4 routes through FIR, else bypass
// (RQ12) Decimation codes map to 4,8,16,32x
// (RQ13) Host writes required fixed bit values
// (RQ14) Sleep bit powers device down
// (RQ15) Reduced-power bit selects low-power mode
// (RQ16) Amp shutdown bit powers amplifier down
// (RQ17) Status mirrors decimation, bypass, low power
// (RQ18) Status flags custom coefficients in use
// (RQ19) Otherwise reads return conversion results
// (RQ20) Power register bits 15 to 4 fixed zero
`timescale 1ns/100ps
module acrb_device_end
    import acrb_pkg::*;
#(
    parameter int MAX_TAPS = 48
)
(
    input  wire logic          core_clk,       // System clock
    input  wire logic          rst_n,          // Sync reset, active low
    acrb_link_if.device        link,           // Link to host
    input  wire logic [23:0]   convResult,     // Latest conversion word
    input  wire logic          overrange,      // Overrange level
    output logic               firEnable,      // Route through FIR
    output acrb_decim_t        decimation,     // Second filter rate
    output logic [3:0]         tapCount,       // Filter tap count code
    output logic               alignPulse,     // Start filter sync
    output logic               deviceSleep,    // Whole-device power down
    output logic               lowPower,       // Reduced-power mode
    output logic               ampShutdown,    // Input amp power down
    output logic               loadActive,     // Coefficient download on
    output logic               customActive,   // Downloaded filter in use
    output logic               checksumMatch,  // Download checksum agreed
    output logic [23:0]        coeffData,      // Last download word, checksum included
    output logic               coeffValid      // Coefficient strobe
);
    acrb_word_t  ctrl1_q;
    acrb_word_t  ctrl2_q;
    acrb_word_t  offset_q;
    acrb_word_t  gain_q;
    acrb_word_t  ovr_q;
    acrb_rdsel_t rdSel_q;
    logic        load_q;
    logic [6:0]  loadLeft_q;
    logic [15:0] sum_q;
    logic        custom_q;
    logic        match_q;
    logic        align_q;
    logic [23:0] rdData_q;
    logic        rdValid_q;
    logic [23:0] cword_q;
    logic        cvalid_q;
    acrb_word_t  status;
    logic        wr1;
    logic        wrLive;

    assign wrLive = link.wrValid && !load_q;  // see RQ2
    assign wr1    = wrLive && link.wrAddr == `ACRB_OFS_CTRL1;

    // Bits 15:9 self-clear: only steady fields are held (see RQ1, RQ9)
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ctrl1_q <= `ACRB_RST_CTRL1;
        else if (wr1)
            ctrl1_q <= {7'h00, link.wrData[8:0]};  // see RQ9
    end

    // Upper power bits never stored (see RQ1, RQ20)
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ctrl2_q <= `ACRB_RST_CTRL2 & `ACRB_C2_LIVE_MASK;
        else if (wrLive && link.wrAddr == `ACRB_OFS_CTRL2)
            ctrl2_q <= link.wrData & `ACRB_C2_LIVE_MASK;  // see RQ20
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            offset_q <= `ACRB_RST_OFFSET;
            gain_q   <= `ACRB_RST_GAIN;
            ovr_q    <= `ACRB_RST_OVR;
        end
        else if (wrLive)
        begin
            if (link.wrAddr == `ACRB_OFS_OFFSET)
                offset_q <= link.wrData;  // see RQ1
            if (link.wrAddr == `ACRB_OFS_GAIN)
                gain_q <= link.wrData;
            if (link.wrAddr == `ACRB_OFS_OVR)
                ovr_q <= link.wrData;
        end
    end

    // Pending readback choice, highest bit wins
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdSel_q <= ACRB_RD_RESULT;
        else if (wr1 && link.wrData[`ACRB_C1_RD_OVR])
            rdSel_q <= ACRB_RD_OVR;  // see RQ4
        else if (wr1 && link.wrData[`ACRB_C1_RD_GAIN])
            rdSel_q <= ACRB_RD_GAIN;  // see RQ5
        else if (wr1 && link.wrData[`ACRB_C1_RD_OFS])
            rdSel_q <= ACRB_RD_OFFSET;  // see RQ6
        else if (wr1 && link.wrData[`ACRB_C1_RD_STAT])
            rdSel_q <= ACRB_RD_STATUS;  // see RQ7
        else if (link.rdReq)
            rdSel_q <= ACRB_RD_RESULT;  // see RQ19
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            align_q <= 1'b0;
        else
            align_q <= wr1 && link.wrData[`ACRB_C1_ALIGN];  // see RQ10
    end

    // Coefficient download: ((tap code+1)/2)*6 words, then a checksum word
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            load_q     <= 1'b0;
            loadLeft_q <= '0;
            sum_q      <= '0;
            custom_q   <= 1'b0;
            match_q    <= 1'b0;
        end
        else if (wr1 && link.wrData[`ACRB_C1_LOAD]
                 && link.wrData[8:5] != 4'h0)
        begin
            load_q     <= 1'b1;  // see RQ2
            loadLeft_q <= 7'(((32'(link.wrData[8:5]) + 1) / 2)
                              * `ACRB_COEF_PER_TAP);
            sum_q      <= '0;
            match_q    <= 1'b0;
        end
        else if (load_q && link.wrValid)
        begin
            if (loadLeft_q != 7'h0)
            begin
                loadLeft_q <= loadLeft_q - 7'h1;
                sum_q <= sum_q + 16'(link.wrAddr) + 16'(link.wrData[15:8])
                       + 16'(link.wrData[7:0]);
            end
            else
            begin
                load_q   <= 1'b0;
                custom_q <= 1'b1;  // see RQ18
                match_q  <= (sum_q == link.wrData);
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cword_q  <= '0;
            cvalid_q <= 1'b0;
        end
        else
        begin
            cvalid_q <= load_q && link.wrValid && loadLeft_q != 7'h0;
            if (load_q && link.wrValid)
                cword_q <= {5'h00, link.wrAddr, link.wrData};
        end
    end

    // Status mirrors live control fields (see RQ17)
    always_comb
    begin
        status = '0;
        status[`ACRB_ST_LOWPWR] = ctrl2_q[`ACRB_C2_LOWPWR];
        status[`ACRB_ST_OVR]    = overrange;
        status[`ACRB_ST_DLOK]   = match_q;
        status[`ACRB_ST_CUSTOM] = custom_q;  // see RQ18
        status[`ACRB_ST_F3EN]   = ctrl1_q[`ACRB_C1_F3EN];
        status[`ACRB_ST_ONE]    = 1'b1;
        status[2:0]             = ctrl1_q[2:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rdData_q  <= '0;
            rdValid_q <= 1'b0;
        end
        else
        begin
            rdValid_q <= link.rdReq;
            if (link.rdReq)
            begin
                case (rdSel_q)
                    ACRB_RD_OVR:    rdData_q <= {8'h00, ovr_q};  // see RQ4
                    ACRB_RD_GAIN:   rdData_q <= {8'h00, gain_q};  // see RQ5
                    ACRB_RD_OFFSET: rdData_q <= {8'h00, offset_q};  // see RQ6
                    ACRB_RD_STATUS: rdData_q <= {8'h00, status};  // see RQ7
                    default:        rdData_q <= convResult;  // see RQ19
                endcase
            end
        end
    end

    // Codes 0..2 all give 4x (see RQ12)
    always_comb
    begin
        case (ctrl1_q[2:0])
            3'h3:    decimation = ACRB_DEC8;
            3'h4:    decimation = ACRB_DEC16;
            3'h5:    decimation = ACRB_DEC32;
            default: decimation = ACRB_DEC4;
        endcase
    end

    assign link.rdValid  = rdValid_q;
    assign link.rdData   = rdData_q;
    assign firEnable     = ctrl1_q[`ACRB_C1_F3EN];  // see RQ11
    assign tapCount      = ctrl1_q[8:5];
    assign alignPulse    = align_q;
    assign deviceSleep   = ctrl2_q[`ACRB_C2_SLEEP];  // see RQ14
    assign lowPower      = ctrl2_q[`ACRB_C2_LOWPWR];  // see RQ15
    assign ampShutdown   = ctrl2_q[`ACRB_C2_AMPOFF];  // see RQ16
    assign loadActive    = load_q;
    assign customActive  = custom_q;
    assign checksumMatch = match_q;
    assign coeffData     = cword_q;
    assign coeffValid    = cvalid_q;
endmodule : acrb_device_end

// [verification/acrb_link_properties.sv]
// Concurrent checks on the host/device config link.
// Assumes instantiation beside acrb_link_if, one clock, sync reset.
`timescale 1ns/100ps
module acrb_link_properties
    import acrb_pkg::*;
(
    input logic        core_clk,  // System clock
    input logic        rst_n,     // Sync reset, active low
    input logic        wrValid,   // Write strobe
    input acrb_addr_t  wrAddr,    // Write address
    input acrb_word_t  wrData,    // Write data
    input logic        rdReq,     // Read request
    input logic        rdValid,   // Read answer strobe
    input logic [23:0] rdData     // Read answer word
);
    logic [6:0] dlLeft_q;
    logic [2:0] dec_q;
    logic       f3_q;
    logic       lp_q;
    acrb_word_t ofs_q;
    acrb_word_t gain_q;
    acrb_word_t ovr_q;
    logic       regWr;

    assign regWr = wrValid && (dlLeft_q == 7'h00);

    // Writes still owed to a coefficient download
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            dlLeft_q <= 7'h00;
        else if (wrValid && dlLeft_q != 7'h00)
            dlLeft_q <= dlLeft_q - 7'h01;
        else if (wrValid && wrAddr == 3'h1 && wrData[15]
                 && wrData[8:5] != 4'h0)
            dlLeft_q <= ({3'h0, wrData[8:5]} + 7'h01) / 7'h02 * 7'h06 + 7'h01;
    end

    // Shadow of the registers that reads can return
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            {f3_q, dec_q} <= 4'ha;
            lp_q <= 1'b0;
            ofs_q <= 16'h0000;
            gain_q <= 16'ha000;
            ovr_q <= 16'hcccc;
        end
        else if (regWr)
        begin
            case (wrAddr)
                3'h1: {f3_q, dec_q} <= {wrData[4], wrData[2:0]};
                3'h2: lp_q <= wrData[2];
                3'h3: ofs_q <= wrData;
                3'h4: gain_q <= wrData;
                3'h5: ovr_q <= wrData;
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_sel_read(logic [3:0] pat);
        regWr && wrAddr == 3'h1 && wrData[14:11] == pat
            ##1 rdReq && !wrValid;
    endsequence

    a_read_answer_next: assert property (rdReq |=> rdValid)
        else $error("read request not answered next cycle");
    a_no_unasked_answer: assert property (!rdReq |=> !rdValid)
        else $error("read answer without request");
    a_read_data_holds: assert property (!rdReq |=> $stable(rdData))
        else $error("read word changed without request");
    a_status_fixed_bits: assert property (s_sel_read(4'b0001) |=>
        rdData[23:16] == 8'h00 && rdData[10] == 1'b0 && rdData[3] == 1'b1)
        else $error("status word fixed bits wrong");
    a_status_mirror: assert property (s_sel_read(4'b0001) |=>
        rdData[2:0] == dec_q && rdData[4] == f3_q && rdData[9] == lp_q)
        else $error("status does not mirror control fields");
    a_ovr_readback: assert property (s_sel_read(4'b1000) |=>
        rdData == {8'h00, ovr_q})
        else $error("overrange threshold readback wrong");
    a_gain_readback: assert property (s_sel_read(4'b0100) |=>
        rdData == {8'h00, gain_q})
        else $error("gain readback wrong");
    a_offset_readback: assert property (s_sel_read(4'b0010) |=>
        rdData == {8'h00, ofs_q})
        else $error("offset readback wrong");
endmodule : acrb_link_properties

// [verification/adc_config_register_bank_tb.sv]
// Self-checking bench: host end and device end joined by the link.
// Assumes the rtl files and the checker are compiled before this file.
`timescale 1ns/100ps
module adc_config_register_bank_tb import acrb_pkg::*;;
`define CHK(a, e) \
    begin \
        n_tests++; \
        if ((a) !== (e)) \
        begin \
            err_total++; \
            $display("wrong value at %0t: %h vs %h", $time, a, e); \
        end \
    end
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cmdWrite = 1'b0;
    logic        cmdRead = 1'b0;
    acrb_addr_t  cmdAddr = 3'h0;
    acrb_word_t  cmdData = 16'h0000;
    logic [23:0] convResult = 24'h5a5a5a;
    logic        overrange = 1'b0;
    logic        cmdReady, rspValid, firEnable, alignPulse, deviceSleep;
    logic        lowPower, ampShutdown, loadActive, customActive;
    logic        checksumMatch, coeffValid;
    logic [23:0] rspData, coeffData, got;
    logic [3:0]  tapCount;
    acrb_decim_t decimation;
    acrb_word_t  ck;
    acrb_word_t  cw;
    int          err_total = 0;
    int          n_tests = 0;
    int          nCoef = 0;
    acrb_decim_t dtab[6] = '{ACRB_DEC4, ACRB_DEC4, ACRB_DEC4, ACRB_DEC8,
                             ACRB_DEC16, ACRB_DEC32};
    acrb_word_t  ldef[3] = '{16'hcccc, 16'ha000, 16'h0000};

    always #20 core_clk = ~core_clk;
    always @(negedge core_clk) nCoef += int'(coeffValid === 1'b1);

    acrb_link_if acrb_link_if_inst (.core_clk(core_clk));
    acrb_host_end acrb_host_end_inst (.core_clk, .rst_n,
        .link(acrb_link_if_inst), .cmdWrite, .cmdRead, .cmdAddr, .cmdData,
        .cmdReady, .rspData, .rspValid);
    acrb_device_end acrb_device_end_inst (.core_clk, .rst_n,
        .link(acrb_link_if_inst), .convResult, .overrange, .firEnable,
        .decimation, .tapCount, .alignPulse, .deviceSleep, .lowPower,
        .ampShutdown, .loadActive, .customActive, .checksumMatch,
        .coeffData, .coeffValid);
    acrb_link_properties acrb_link_properties_inst (.core_clk, .rst_n,
        .wrValid(acrb_link_if_inst.wrValid), .wrAddr(acrb_link_if_inst.wrAddr),
        .wrData(acrb_link_if_inst.wrData), .rdReq(acrb_link_if_inst.rdReq),
        .rdValid(acrb_link_if_inst.rdValid), .rdData(acrb_link_if_inst.rdData));

    task automatic wr(input acrb_addr_t a, input acrb_word_t d);
        @(negedge core_clk);
        while (cmdReady !== 1'b1) @(negedge core_clk);
        cmdWrite = 1'b1;
        cmdAddr = a;
        cmdData = d;
        @(negedge core_clk);
        cmdWrite = 1'b0;
    endtask : wr

    task automatic rd(output logic [23:0] q);
        @(negedge core_clk);
        while (cmdReady !== 1'b1) @(negedge core_clk);
        cmdRead = 1'b1;
        @(negedge core_clk);
        cmdRead = 1'b0;
        @(negedge core_clk);
        `CHK(rspValid, 1'b1)
        q = rspData;
    endtask : rd

    // Status word with bit 6 and bits 23 to 10 masked off; checksum bit expected equal to custom flag
    function automatic logic [23:0] stat(input logic [2:0] dc,
        input logic f3, input logic lp, input logic ov, input logic cu);
        return {14'h0000, lp, ov, cu, 1'b0, cu, f3, 1'b1, dc};
    endfunction : stat

    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        give_verdict();
    end

    initial
    begin
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        `CHK({firEnable, decimation, tapCount}, {1'b1, ACRB_DEC4, 4'h0})
        `CHK({deviceSleep, lowPower, ampShutdown}, 3'b101)
        for (int c = 0; c < 6; c++)
        begin
            overrange = c[0];
            wr(3'h1, {4'h0, 1'b1, 6'h00, c[0], 1'b1, c[2:0]});
            rd(got);
            `CHK(got & 24'h0003bf, stat(c[2:0], c[0], 1'b0, c[0], 1'b0))
            `CHK(decimation, dtab[c])
            `CHK(firEnable, c[0])
            rd(got);
            `CHK(got, convResult)
        end
        overrange = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            wr(3'h1, (16'h4000 >> i) | 16'h001a);
            rd(got);
            `CHK(got, {8'h00, ldef[i]})
            wr(3'h5 - 3'(i), 16'h0f00 + 16'(i));
            wr(3'h1, (16'h4000 >> i) | 16'h001a);
            rd(got);
            `CHK(got, {8'h00, 16'h0f00 + 16'(i)})
            rd(got);
            `CHK(got, convResult)
        end
        wr(3'h2, 16'hfffd);
        wr(3'h6, 16'h0000);
        wr(3'h1, 16'h081a);
        rd(got);
        `CHK({deviceSleep, lowPower, ampShutdown}, 3'b111)
        `CHK(got & 24'h0003bf, stat(3'h2, 1'b1, 1'b1, 1'b0, 1'b0))
        wr(3'h2, 16'h0002);
        wr(3'h7, 16'hffff);
        `CHK({deviceSleep, lowPower, ampShutdown}, 3'b000)
        wr(3'h1, 16'h021a);
        `CHK(alignPulse, 1'b0)
        @(negedge core_clk);
        `CHK(alignPulse, 1'b1)
        @(negedge core_clk);
        `CHK(alignPulse, 1'b0)
        wr(3'h1, 16'h803a);
        ck = 16'h0000;
        for (int i = 1; i <= 6; i++)
        begin
            cw = 16'h0808 * 16'(i);
            ck += 16'h0003 + {8'h00, cw[15:8]} + {8'h00, cw[7:0]};
            wr(3'h3, cw);
        end
        @(negedge core_clk);
        `CHK(loadActive, 1'b1)
        `CHK(coeffData, {5'h00, 3'h3, 16'h3030})
        wr(3'h3, ck);
        wr(3'h1, 16'h083a);
        rd(got);
        `CHK(nCoef, 6)
        `CHK(tapCount, 4'h1)
        `CHK({loadActive, customActive, checksumMatch}, 3'b011)
        `CHK(got & 24'h0003bf, stat(3'h2, 1'b1, 1'b0, 1'b0, 1'b1))
        wr(3'h1, 16'h101a);
        rd(got);
        `CHK(got, 24'h000f02)
        give_verdict();
    end
endmodule : adc_config_register_bank_tb
